// ---- include/mrh_defines.svh ----
// Constants for the mode register one/two programming controller.
// Assumes inclusion by bare name from files that need offsets and fields.
`ifndef MRH_DEFINES_SVH
`define MRH_DEFINES_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MRH_OFS_CTRL 8'h00
`define MRH_OFS_MR1 8'h04
`define MRH_OFS_MR2 8'h08
`define MRH_OFS_STAT 8'h0C
`define MRH_OFS_MR1_SH 8'h10
`define MRH_OFS_MR2_SH 8'h14
// ****************************************
// Control and status fields
// ****************************************
`define MRH_CTL_GO1 0
`define MRH_CTL_GO2 1
`define MRH_CTL_LOCK 2
`define MRH_CTL_X16 3
`define MRH_CTL_WRTT 4
`define MRH_CTL_EXT 5
`define MRH_ST_BUSY 0
`define MRH_ST_LOCKING 1
`define MRH_ST_LOCKED 2
`define MRH_ST_DLLOFF 3
`define MRH_ST_ERR1 8
`define MRH_ST_ERR2 9
// ****************************************
// Mode register fields
// ****************************************
`define MRH_MR1_DLL_OFF 0
`define MRH_MR1_RTT_A2 2
`define MRH_MR1_RTT_A6 6
`define MRH_MR1_WLVL 7
`define MRH_MR1_RTT_A9 9
`define MRH_MR1_TERMINATION_STROBE 11
`define MRH_MR1_QOFF 12
`define MRH_MR1_RSVD 16'hE500
`define MRH_MR2_ASR 6
`define MRH_MR2_SRT 7
`define MRH_MR2_RTTWR_LO 9
`define MRH_MR2_RTTWR_HI 10
`define MRH_MR2_RSVD 16'hF920
`define MRH_BA_MR1 3'h1
`define MRH_BA_MR2 3'h2
// ****************************************
// Reset values and timing counts
// ****************************************
`define MRH_CFG_RST 16'h0000
`define MRH_LOCK_CYCLES 512
`define MRH_MRD_CYCLES 4
`endif

// ---- include/mrh_pkg.sv ----
// Types shared by the mode register programming controller.
// Assumes nothing beyond a SystemVerilog compiler.
package mrh_pkg;
    typedef enum logic [3:0] {
        MRH_IDLE = 4'b0001,
        MRH_CHECK = 4'b0010,
        MRH_ISSUE = 4'b0100,
        MRH_WAIT = 4'b1000
    } mrh_state_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [15:0] addr;
    } mrh_cmd_s;
endpackage : mrh_pkg

// ---- core/mrh_lock_timer.sv ----
// Lock wait timer: counts the DLL lock interval after a DLL reset.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "mrh_defines.svh"
module mrh_lock_timer #(
    parameter int LOCK_CYCLES = `MRH_LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic busy,
    output logic done
);
    import mrh_pkg::*;
    localparam int CW = $clog2(LOCK_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(LOCK_CYCLES);

    logic [CW-1:0] cnt_reg;
    logic busy_reg;
    logic done_reg;
    wire last = busy_reg && (cnt_reg == CW'(1));

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg <= LOAD;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end
        else if (busy_reg)
        begin
            cnt_reg <= cnt_reg - CW'(1);
            busy_reg <= !last;
            done_reg <= last;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

    // Lock wait ends only after the full count has elapsed
    chk_lock_full_span: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(busy_reg) && !$past(start) |-> $past(cnt_reg) == CW'(1) && done_reg)
        else $error("lock wait ended early");
endmodule : mrh_lock_timer

// ---- core/mrh_ctrl.sv ----
// Host controller that programs mode registers one and two over the command pins.
// Assumes an APB master, a synchronous DRAM command bus and one 20 MHz clock.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "mrh_defines.svh"
module mrh_ctrl #(
    parameter int LOCK_CYCLES = `MRH_LOCK_CYCLES,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cke_req,
    input wire logic odt_req,
    output mrh_pkg::mrh_cmd_s ddr_cmd,
    output logic cke,
    output logic odt,
    output logic rd_allow
);
    import mrh_pkg::*;

    // ****************************************
    // Field helpers
    // ****************************************
    function automatic logic [2:0] rtt_of(input logic [15:0] v);
        rtt_of = {v[`MRH_MR1_RTT_A9], v[`MRH_MR1_RTT_A6], v[`MRH_MR1_RTT_A2]};
    endfunction : rtt_of

    // Codes 1..3 are the half, quarter and sixth reference_resistor settings
    function automatic logic rtt_strong(input logic [2:0] r);
        rtt_strong = (r == 3'h1) || (r == 3'h2) || (r == 3'h3);
    endfunction : rtt_strong

    function automatic logic [15:0] fix_mr1(input logic [15:0] v, input logic x16);
        logic [15:0] f;
        f = v & ~`MRH_MR1_RSVD;
        if (x16)
            f[`MRH_MR1_TERMINATION_STROBE] = 1'b0;
        if (f[`MRH_MR1_DLL_OFF])
        begin
            f[`MRH_MR1_RTT_A9] = 1'b0;
            f[`MRH_MR1_RTT_A6] = 1'b0;
            f[`MRH_MR1_RTT_A2] = 1'b0;
        end
        fix_mr1 = f;
    endfunction : fix_mr1

    function automatic logic [15:0] fix_mr2(input logic [15:0] v, input logic dll_off,
                                            input logic ext);
        logic [15:0] f;
        f = v & ~`MRH_MR2_RSVD;
        if (dll_off)
            f[`MRH_MR2_RTTWR_HI:`MRH_MR2_RTTWR_LO] = 2'h0;
        if (ext && !f[`MRH_MR2_ASR])
            f[`MRH_MR2_SRT] = 1'b1;
        fix_mr2 = f;
    endfunction : fix_mr2

    // ****************************************
    // State
    // ****************************************
    mrh_state_e state_reg, state_next;
    logic [5:0] ctl_reg;
    logic [15:0] mr1_cfg_reg, mr2_cfg_reg, mr1_sh_reg, mr2_sh_reg, val_reg;
    logic tgt2_reg, go1_reg, go2_reg, err1_reg, err2_reg, dll_off_reg;
    logic [2:0] gap_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, cke_reg, odt_reg, rd_allow_reg;
    mrh_cmd_s cmd_reg, cmd_next;
    logic lock_busy, lock_done;

    // ****************************************
    // APB slave decode
    // ****************************************
    wire acc = psel && penable;
    wire first = acc && !pready_reg;
    wire wr_take = acc && pready_reg && pwrite;
    wire hit_ctrl = paddr == AW'(`MRH_OFS_CTRL);
    wire hit_mr1 = paddr == AW'(`MRH_OFS_MR1);
    wire hit_mr2 = paddr == AW'(`MRH_OFS_MR2);
    wire hit_stat = paddr == AW'(`MRH_OFS_STAT);
    wire hit_sh1 = paddr == AW'(`MRH_OFS_MR1_SH);
    wire hit_sh2 = paddr == AW'(`MRH_OFS_MR2_SH);
    wire hit = hit_ctrl || hit_mr1 || hit_mr2 || hit_stat || hit_sh1 || hit_sh2;
    wire w_ctrl = wr_take && hit_ctrl;
    wire w_stat = wr_take && hit_stat;
    wire lock_start = w_ctrl && pwdata[`MRH_CTL_LOCK];
    wire is_busy = state_reg != MRH_IDLE || go1_reg || go2_reg;
    wire [31:0] stat_word = {22'h0, err2_reg, err1_reg, 4'h0, dll_off_reg, lock_done,
                             lock_busy, is_busy};
    wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctl_reg} :
                         hit_mr1 ? {16'h0, mr1_cfg_reg} :
                         hit_mr2 ? {16'h0, mr2_cfg_reg} :
                         hit_stat ? stat_word :
                         hit_sh1 ? {16'h0, mr1_sh_reg} :
                         hit_sh2 ? {16'h0, mr2_sh_reg} : 32'h0;

    // ****************************************
    // Mode register preparation
    // ****************************************
    wire x16 = ctl_reg[`MRH_CTL_X16];
    wire [15:0] mr1_fix = fix_mr1(mr1_cfg_reg, x16);
    wire [15:0] mr2_fix = fix_mr2(mr2_cfg_reg, dll_off_reg, ctl_reg[`MRH_CTL_EXT]);
    wire [2:0] rtt1 = rtt_of(mr1_fix);
    wire lvl_bad = mr1_fix[`MRH_MR1_WLVL] && !mr1_fix[`MRH_MR1_QOFF] && !rtt_strong(rtt1);
    wire wrt_bad = ctl_reg[`MRH_CTL_WRTT] && rtt1 != 3'h0 && !rtt_strong(rtt1);
    wire mr1_ok = !lvl_bad && !wrt_bad;
    wire take2 = !go1_reg && go2_reg;
    wire chk_ok = tgt2_reg || mr1_ok;
    wire gap_end = gap_reg == 3'(`MRH_MRD_CYCLES - 1);
    wire err1_set = state_reg == MRH_CHECK && !chk_ok;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        cmd_next = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 3'h0, addr: 16'h0};
        case (state_reg)
            MRH_IDLE:
                if (go1_reg || go2_reg)
                    state_next = MRH_CHECK;
            MRH_CHECK:
            begin
                state_next = chk_ok ? MRH_ISSUE : MRH_IDLE;
                if (chk_ok)
                begin
                    cmd_next = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b0,
                                 ba: tgt2_reg ? `MRH_BA_MR2 : `MRH_BA_MR1,
                                 addr: tgt2_reg ? mr2_fix : mr1_fix};
                end
            end
            MRH_ISSUE:
                state_next = MRH_WAIT;
            MRH_WAIT:
                if (gap_end)
                    state_next = MRH_IDLE;
            default:
                state_next = MRH_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= MRH_IDLE;
            cmd_reg <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 3'h0, addr: 16'h0};
            tgt2_reg <= 1'b0;
            gap_reg <= 3'h0;
            val_reg <= `MRH_CFG_RST;
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            gap_reg <= state_reg == MRH_WAIT ? gap_reg + 3'h1 : 3'h0;
            if (state_reg == MRH_IDLE)
                tgt2_reg <= take2;
            if (state_reg == MRH_CHECK)
                val_reg <= cmd_next.addr;
        end
    end

    // Shadows change only on an issued set command to that register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mr1_sh_reg <= `MRH_CFG_RST;
            mr2_sh_reg <= `MRH_CFG_RST;
            dll_off_reg <= 1'b0;
        end
        else if (state_reg == MRH_ISSUE && !tgt2_reg)
        begin
            mr1_sh_reg <= val_reg;
            dll_off_reg <= val_reg[`MRH_MR1_DLL_OFF];
        end
        else if (state_reg == MRH_ISSUE)
            mr2_sh_reg <= val_reg;
    end

    // ****************************************
    // Register file
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctl_reg <= 6'h0;
            mr1_cfg_reg <= `MRH_CFG_RST;
            mr2_cfg_reg <= `MRH_CFG_RST;
            go1_reg <= 1'b0;
            go2_reg <= 1'b0;
            err1_reg <= 1'b0;
            err2_reg <= 1'b0;
        end
        else
        begin
            if (w_ctrl)
                ctl_reg <= {pwdata[5:3], 3'h0};
            if (wr_take && hit_mr1)
                mr1_cfg_reg <= pwdata[15:0];
            if (wr_take && hit_mr2)
                mr2_cfg_reg <= pwdata[15:0];
            // A new request landing as the old one is taken is kept
            go1_reg <= (w_ctrl && pwdata[`MRH_CTL_GO1])
                       || (go1_reg && !(state_reg == MRH_IDLE));
            go2_reg <= (w_ctrl && pwdata[`MRH_CTL_GO2])
                       || (go2_reg && !(state_reg == MRH_IDLE && take2));
            err1_reg <= err1_set || (err1_reg && !(w_stat && pwdata[`MRH_ST_ERR1]));
            err2_reg <= (w_ctrl && pwdata[`MRH_CTL_GO2] && go2_reg)
                        || (err2_reg && !(w_stat && pwdata[`MRH_ST_ERR2]));
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end
        else
        begin
            pready_reg <= first;
            pslverr_reg <= first && !hit;
            if (first && !pwrite)
                prdata_reg <= rd_mux;
        end
    end

    // ****************************************
    // DLL lock wait and pin gating
    // ****************************************
    mrh_lock_timer #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_lock (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(lock_start),
        .busy(lock_busy),
        .done(lock_done)
    );

    // Termination also waits for lock, so it stays off until software runs one
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cke_reg <= 1'b0;
            odt_reg <= 1'b0;
            rd_allow_reg <= 1'b0;
        end
        else
        begin
            cke_reg <= cke_req || lock_busy || lock_start;
            odt_reg <= odt_req && lock_done && !lock_start && !dll_off_reg;
            rd_allow_reg <= lock_done && !lock_start;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ddr_cmd = cmd_reg;
    assign cke = cke_reg;
    assign odt = odt_reg;
    assign rd_allow = rd_allow_reg;

    // ****************************************
    // Checks
    // ****************************************
    wire is_mrs = !cmd_reg.cs_n && !cmd_reg.ras_n && !cmd_reg.cas_n && !cmd_reg.we_n;
    wire mrs1 = is_mrs && cmd_reg.ba == `MRH_BA_MR1;
    wire mrs2 = is_mrs && cmd_reg.ba == `MRH_BA_MR2;

    chk_mr1_cmd_code: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == MRH_CHECK && chk_ok && !tgt2_reg
        |=> mrs1 ##1 (cmd_reg.cs_n && mr1_sh_reg == $past(cmd_reg.addr)))
        else $error("mode_reg_one command or its shadow wrong");
    chk_mr2_cmd_code: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == MRH_CHECK && tgt2_reg |=> mrs2 ##1 cmd_reg.cs_n)
        else $error("mode_reg_two command wrong or held");
    chk_mr1_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
        mrs1 |-> (cmd_reg.addr & `MRH_MR1_RSVD) == 16'h0)
        else $error("reserved mode_reg_one bit set");
    chk_mr2_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
        mrs2 |-> (cmd_reg.addr & `MRH_MR2_RSVD) == 16'h0)
        else $error("reserved mode_reg_two bit set");
    chk_wlvl_rtt_code: assert property (@(posedge clk) disable iff (sys_rst)
        mrs1 && cmd_reg.addr[`MRH_MR1_WLVL] && !cmd_reg.addr[`MRH_MR1_QOFF]
        |-> rtt_strong(rtt_of(cmd_reg.addr)))
        else $error("leveling termination code not allowed");
    chk_write_rtt_code: assert property (@(posedge clk) disable iff (sys_rst)
        mrs1 && $past(ctl_reg[`MRH_CTL_WRTT]) && rtt_of(cmd_reg.addr) != 3'h0
        |-> rtt_strong(rtt_of(cmd_reg.addr)))
        else $error("write termination code not allowed");
    chk_read_after_lock: assert property (@(posedge clk) disable iff (sys_rst)
        lock_start || lock_busy |=> !rd_allow_reg && !odt_reg)
        else $error("read or termination allowed during lock wait");
    chk_cke_during_lock: assert property (@(posedge clk) disable iff (sys_rst)
        lock_start || lock_busy |=> cke_reg)
        else $error("clock enable low during lock wait");
    chk_dll_off_odt: assert property (@(posedge clk) disable iff (sys_rst)
        dll_off_reg |=> !odt_reg)
        else $error("termination pin driven in dll-off mode");
    chk_dll_off_dyn: assert property (@(posedge clk) disable iff (sys_rst)
        mrs2 && $past(dll_off_reg)
        |-> cmd_reg.addr[`MRH_MR2_RTTWR_HI:`MRH_MR2_RTTWR_LO] == 2'h0)
        else $error("dynamic termination left on in dll-off mode");
    chk_x16_termination_strobe_off: assert property (@(posedge clk) disable iff (sys_rst)
        mrs1 && $past(x16) |-> !cmd_reg.addr[`MRH_MR1_TERMINATION_STROBE])
        else $error("termination strobe on for sixteen-bit part");
    chk_ext_temp_sr: assert property (@(posedge clk) disable iff (sys_rst)
        mrs2 && $past(ctl_reg[`MRH_CTL_EXT])
        |-> cmd_reg.addr[`MRH_MR2_ASR] || cmd_reg.addr[`MRH_MR2_SRT])
        else $error("extended temperature self-refresh not set up");
endmodule : mrh_ctrl

// ---- verif/mrh_dev_model.sv ----
// Behavioural DRAM device that latches mode registers one and two.
// Assumes commands are sampled on the rising edge of clk.
`timescale 1ns/1ps
module mrh_dev_model #(
    parameter int CAS_LAT = 6,
    parameter int CWL_BASE = 5
) (
    input wire logic clk,
    input wire mrh_pkg::mrh_cmd_s ddr_cmd,
    input wire logic cke,
    input wire logic odt,
    output logic [15:0] mr1_reg,
    output logic [15:0] mr2_reg,
    output logic [2:0] last_ba,
    output int n_mrs
);
    import mrh_pkg::*;
    logic is_mrs;
    logic [3:0] add_lat;
    logic [4:0] rd_lat;
    logic [4:0] wr_lat;
    logic [1:0] drv_sel;
    logic dll_on;
    logic out_off;
    logic dm_shared;
    logic rtt_wr_on;
    logic term_on;
    // ****************************************
    // Decodes seen by the device core
    // ****************************************
    assign is_mrs = !ddr_cmd.cs_n && !ddr_cmd.ras_n && !ddr_cmd.cas_n && !ddr_cmd.we_n;
    assign add_lat = (mr1_reg[4:3] == 2'b01) ? 4'(CAS_LAT - 1) :
        (mr1_reg[4:3] == 2'b10) ? 4'(CAS_LAT - 2) : 4'h0;
    assign rd_lat = 5'(add_lat) + 5'(CAS_LAT);
    assign wr_lat = 5'(add_lat) + 5'(mr2_reg[5:3]) + 5'(CWL_BASE);
    assign drv_sel = {mr1_reg[5], mr1_reg[1]};
    assign dll_on = !mr1_reg[0];
    assign out_off = mr1_reg[12];
    assign dm_shared = !mr1_reg[11];
    assign rtt_wr_on = (mr2_reg[10:9] != 2'b00) && !mr1_reg[7];
    assign term_on = odt && cke;
    initial
    begin
        mr1_reg = 16'h0000;
        mr2_reg = 16'h0000;
        last_ba = 3'h0;
        n_mrs = 0;
    end
    // Clock enable low makes the device ignore commands
    always @(posedge clk)
    begin
        if (is_mrs && cke)
        begin
            n_mrs <= n_mrs + 1;
            last_ba <= ddr_cmd.ba;
            if (ddr_cmd.ba == 3'h1)
                mr1_reg <= ddr_cmd.addr;
            if (ddr_cmd.ba == 3'h2)
                mr2_reg <= ddr_cmd.addr;
        end
    end
endmodule : mrh_dev_model

// ---- verif/mrh_ctrl_tb_top.sv ----
// Testbench for the mode register programming controller over APB.
// Assumes the device model and the shared package and defines.
`timescale 1ns/1ps
`include "mrh_defines.svh"
module mrh_ctrl_tb_top;
    import mrh_pkg::*;
    localparam int LOCK = 8;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cke_req = 1'b0;
    logic odt_req = 1'b0;
    mrh_cmd_s ddr_cmd;
    logic cke;
    logic odt;
    logic rd_allow;
    logic [15:0] mr1_seen;
    logic [15:0] mr2_seen;
    logic [2:0] ba_seen;
    int n_mrs;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    logic [31:0] rd_q;
    logic err_q;
    logic [15:0] c1_cfg [7] = '{16'hE50A, 16'h0280, 16'h1280, 16'h0240, 16'h0004,
        16'h0800, 16'h0805};
    logic [7:0] c1_ctl [7] = '{8'h01, 8'h01, 8'h01, 8'h11, 8'h11, 8'h09, 8'h01};
    logic [15:0] c1_exp [7] = '{16'h000A, 16'h000A, 16'h1280, 16'h1280, 16'h0004,
        16'h0000, 16'h0801};
    logic [11:0] c1_st [7] = '{12'h000, 12'h100, 12'h000, 12'h100, 12'h000, 12'h000, 12'h00C};
    mrh_ctrl #(.LOCK_CYCLES(LOCK), .AW(8)) u_mrh_ctrl (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cke_req(cke_req),
        .odt_req(odt_req), .ddr_cmd(ddr_cmd), .cke(cke), .odt(odt), .rd_allow(rd_allow));
    mrh_dev_model u_mrh_dev_model (.clk(clk), .ddr_cmd(ddr_cmd), .cke(cke), .odt(odt),
        .mr1_reg(mr1_seen), .mr2_reg(mr2_seen), .last_ba(ba_seen), .n_mrs(n_mrs));
    always #25 clk = ~clk;
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // Hang guard, far above the roughly 410 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
        chk("slverr", {31'h0, a > 8'h14}, {31'h0, err_q});
    endtask : rd
    // Fixed wait: three cycles to the command, a four cycle gap and one spare cycle
    task automatic mrs_go(input logic [7:0] a, input logic [15:0] cfg, input logic [7:0] ctl);
        apb(1'b1, a, {16'hFFFF, cfg});
        apb(1'b1, `MRH_OFS_CTRL, {24'h0, ctl});
        repeat (8) @(posedge clk);
    endtask : mrs_go
    task automatic mr1_case(input int i);
        int n0;
        n0 = n_mrs;
        mrs_go(`MRH_OFS_MR1, c1_cfg[i], c1_ctl[i]);
        chk("mr1_dev", {16'h0, c1_exp[i]}, {16'h0, mr1_seen});
        chk("mrs_count", n0 + (c1_st[i][8] ? 0 : 1), n_mrs);
        chk("mr1_ba", 32'h1, {29'h0, ba_seen});
        rd("mr1_shadow", `MRH_OFS_MR1_SH, {16'h0, c1_exp[i]});
        rd("mr1_cfg", `MRH_OFS_MR1, {16'h0, c1_cfg[i]});
        rd("stat", `MRH_OFS_STAT, {20'h0, c1_st[i]});
        apb(1'b1, `MRH_OFS_STAT, 32'h300);
        rd("stat_clr", `MRH_OFS_STAT, {20'h0, c1_st[i] & 12'h0FF});
    endtask : mr1_case
    task automatic mr2_case(input logic [15:0] cfg, input logic [7:0] ctl, input logic [15:0] e);
        mrs_go(`MRH_OFS_MR2, cfg, ctl);
        chk("mr2_dev", {16'h0, e}, {16'h0, mr2_seen});
        chk("mr2_ba", 32'h2, {29'h0, ba_seen});
        rd("mr2_shadow", `MRH_OFS_MR2_SH, {16'h0, e});
    endtask : mr2_case
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 24; a += 4)
            rd("reset_val", 8'(a), 32'h0);
        apb(1'b1, `MRH_OFS_MR1_SH, 32'hFFFF);
        rd("ro_shadow", `MRH_OFS_MR1_SH, 32'h0);
        apb(1'b1, 8'h18, 32'h1);
        chk("wr_unmapped", 32'h1, {31'h0, err_q});
        chk("cke_rst", 32'h0, {30'h0, cke, rd_allow});
        cke_req <= 1'b1;
        mr2_case(16'hFFFF, 8'h02, 16'h06DF);
        for (int i = 0; i < 6; i++)
            mr1_case(i);
        rd("ctrl_rb", `MRH_OFS_CTRL, 32'h08);
        chk("mr2_kept", 32'h06DF, {16'h0, mr2_seen});
        cke_req <= 1'b0;
        odt_req <= 1'b1;
        apb(1'b1, `MRH_OFS_CTRL, 32'h4);
        n = 0;
        while (rd_allow !== 1'b1 && n < LOCK + 20)
        begin
            @(posedge clk);
            n++;
            if (n >= 1 && rd_allow !== 1'b1)
            begin
                chk("cke_lock", 32'h1, {31'h0, cke});
                chk("odt_lock", 32'h0, {31'h0, odt});
            end
        end
        chk("lock_len", LOCK + 2, n);
        repeat (2) @(posedge clk);
        chk("after_lock", 32'h1, {30'h0, cke, odt});
        cke_req <= 1'b1;
        mr1_case(6);
        chk("odt_dll_off", 32'h0, {31'h0, odt});
        mr2_case(16'h0600, 8'h22, 16'h0080);
        mr2_case(16'h0640, 8'h22, 16'h0040);
        chk("mr1_kept", 32'h0801, {16'h0, mr1_seen});
        // Both requests at once, then a second one while the first is still pending
        n = n_mrs;
        apb(1'b1, `MRH_OFS_CTRL, 32'h3);
        apb(1'b1, `MRH_OFS_CTRL, 32'h2);
        repeat (16) @(posedge clk);
        chk("mrs_pair", n + 2, n_mrs);
        chk("pair_last_ba", 32'h2, {29'h0, ba_seen});
        chk("pair_mr2", 32'h0040, {16'h0, mr2_seen});
        rd("stat_err2", `MRH_OFS_STAT, 32'h20C);
        complete_run();
    end
endmodule : mrh_ctrl_tb_top
